// ### core/power_seq.sv
// low-voltage reset and ram back-up sequencer
`timescale 1ns/1ps
`include "power_seq_consts.svh"

// What this block does
// - detector fires a system reset on supply drop
// - backup detect instruction latches once until reset
// - enable pin low disables detector everywhere
// - backup detection needs instruction while pin high
// - arm then enter starts ram back-up
// - enter without arm acts as no-op
// - back-up stops oscillator, ram is kept
// - powerdown flag answers skip instruction
// - wakeup resumes at zero, flag set
// - four cold sources restart at zero, flag cleared
// - listed control registers retained across back-up
// - listed core registers initialised by back-up
// - stack pointer becomes seven on back-up
// - timer state undefined after back-up
// - other registers reload initial values on return
// - back-up initialises watchdog and its flags
// - counter pin low or hi-z in back-up
// - only external wakeup leaves back-up without reset
module power_seq #(
    parameter int RESET_CYCLES = 4
) (
    input  wire logic                       clk_in,
    input  wire logic                       arst_n_in,
    input  wire power_seq_pkg::instr_s      instr_in,
    input  wire power_seq_pkg::reset_src_s  reset_src_in,
    input  wire logic                       detector_enable_pin_in,
    input  wire logic                       supply_low_in,
    input  wire logic                       wakeup_in,
    input  wire logic                       counter_mode_bit_hi_in,
    input  wire logic                       counter_mode_bit_lo_in,
    output logic                            system_reset_out,
    output logic                            osc_stop_out,
    output logic                            backup_out,
    output logic                            detector_active_out,
    output logic                            powerdown_flag_out,
    output logic                            skip_out,
    output logic                            core_init_out,
    output logic [2:0]                      stack_pointer_out,
    output logic                            watchdog_init_out,
    output logic                            watchdog_enable_flag_out,
    output logic                            counter_io_pin_o_out,
    output logic                            counter_io_pin_oe_out,
    output logic [13:0]                     pc_load_out
);

    typedef enum logic [1:0] {
        ST_RUN,
        ST_BACKUP,
        ST_RESET
    } state_e;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] detector_enable_pin_q;
    logic [2:0] low_q;
    logic [2:0] wake_q;
    logic [2:0] rpin_q;
    logic       detector_enable_pin_s_q;
    logic       low_s_q;
    logic       wake_s_q;
    logic       rpin_s_q;

    // three-stage shift, filtered value moves when stages two and three agree
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            detector_enable_pin_q   <= 3'h0;
            low_q    <= 3'h0;
            wake_q   <= 3'h0;
            rpin_q   <= 3'h0;
            detector_enable_pin_s_q <= 1'b0;
            low_s_q  <= 1'b0;
            wake_s_q <= 1'b0;
            rpin_s_q <= 1'b0;
        end else begin
            detector_enable_pin_q <= {detector_enable_pin_q[1:0], detector_enable_pin_in};
            low_q  <= {low_q[1:0], supply_low_in};
            wake_q <= {wake_q[1:0], wakeup_in};
            rpin_q <= {rpin_q[1:0], reset_src_in.reset_pin};
            if (detector_enable_pin_q[1] == detector_enable_pin_q[2]) detector_enable_pin_s_q <= detector_enable_pin_q[2];
            if (low_q[1] == low_q[2]) low_s_q <= low_q[2];
            if (wake_q[1] == wake_q[2]) wake_s_q <= wake_q[2];
            if (rpin_q[1] == rpin_q[2]) rpin_s_q <= rpin_q[2];
        end
    end

    // ------------------------------------------------------------
    // state and flags
    // ------------------------------------------------------------
    state_e     state_q;
    state_e     state_d;
    logic       arm_q;
    logic       detect_in_backup_instr_q;
    logic       pflag_q;
    logic [3:0] rst_cnt_q;

    wire in_backup   = (state_q == ST_BACKUP);
    wire in_run      = (state_q == ST_RUN);
    // detector validity table: pin gates all, backup needs latched instruction
    wire det_active  = detector_enable_pin_s_q && (in_run || (in_backup && detect_in_backup_instr_q));
    wire drop_reset  = det_active && low_s_q;
    wire cold_event  = rpin_s_q || reset_src_in.watchdog || drop_reset ||
                       (in_run && instr_in.software_reset);
    wire enter_ok    = in_run && arm_q && instr_in.enter;
    wire wake_event  = in_backup && wake_s_q;
    wire cnt_input   = ({counter_mode_bit_hi_in, counter_mode_bit_lo_in} ==
                        `CNTR_MODE_INPUT);
    wire rst_done    = (rst_cnt_q == 4'(RESET_CYCLES - 1));

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (cold_event) state_d = ST_RESET;
                else if (enter_ok) state_d = ST_BACKUP;
            end
            ST_BACKUP: begin
                if (cold_event) state_d = ST_RESET;
                else if (wake_event) state_d = ST_RUN;
            end
            ST_RESET: begin
                if (rst_done && !cold_event) state_d = ST_RUN;
            end
            default: state_d = ST_RESET;
        endcase
    end

    // state register and reset pulse counter
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q   <= ST_RESET;
            rst_cnt_q <= 4'h0;
        end else begin
            state_q   <= state_d;
            rst_cnt_q <= (state_q == ST_RESET && !rst_done) ? rst_cnt_q + 4'h1 : 4'h0;
        end
    end

    // arm latch: only a directly following enter consumes it
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            arm_q <= 1'b0;
        end else if (!in_run || cold_event) begin
            arm_q <= 1'b0;
        end else if (instr_in.arm) begin
            arm_q <= 1'b1;
        end else if (instr_in.enter || instr_in.other || instr_in.detect_in_backup ||
                     instr_in.skip_if_powerdown) begin
            arm_q <= 1'b0;
        end
    end

    // detect-in-backup latch, one-shot, only a system reset clears it
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            detect_in_backup_instr_q <= 1'b0;
        end else if (state_q == ST_RESET) begin
            detect_in_backup_instr_q <= 1'b0;
        end else if (in_run && instr_in.detect_in_backup) begin
            detect_in_backup_instr_q <= 1'b1;
        end
    end

    // powerdown flag: warm return sets, cold sources clear
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pflag_q <= `PFLAG_COLD;
        end else if (cold_event) begin
            pflag_q <= `PFLAG_COLD;
        end else if (wake_event) begin
            pflag_q <= `PFLAG_WARM;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            system_reset_out         <= 1'b1;
            osc_stop_out             <= 1'b0;
            backup_out               <= 1'b0;
            detector_active_out      <= 1'b0;
            powerdown_flag_out       <= `PFLAG_COLD;
            skip_out                 <= 1'b0;
            core_init_out            <= 1'b0;
            stack_pointer_out        <= `SP_INIT_VALUE;
            watchdog_init_out        <= 1'b0;
            watchdog_enable_flag_out <= `WEF_RESET_VALUE;
            counter_io_pin_o_out     <= 1'b0;
            counter_io_pin_oe_out    <= 1'b0;
            pc_load_out              <= `RESET_VECTOR_ADDR;
        end else begin
            system_reset_out    <= (state_d == ST_RESET);
            osc_stop_out        <= (state_d == ST_BACKUP);
            backup_out          <= (state_d == ST_BACKUP);
            detector_active_out <= det_active;
            powerdown_flag_out  <= pflag_q;
            skip_out            <= in_run && instr_in.skip_if_powerdown && pflag_q;
            // core registers, stack pointer, watchdog and its enable flag reloaded on entry
            core_init_out       <= enter_ok;
            if (enter_ok) stack_pointer_out <= `SP_INIT_VALUE;
            watchdog_init_out   <= enter_ok;
            if (enter_ok || state_q == ST_RESET) watchdog_enable_flag_out <= `WEF_RESET_VALUE;
            // counter pin: low in back-up, released when counter input selected
            counter_io_pin_o_out  <= 1'b0;
            counter_io_pin_oe_out <= (state_d == ST_BACKUP) && !cnt_input;
            pc_load_out           <= `RESET_VECTOR_ADDR;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_DROP_RESET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        drop_reset |=> system_reset_out)
        else $error("supply drop did not reset");
    AST_PIN_LOW_OFF: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !detector_enable_pin_s_q |=> !detector_active_out)
        else $error("detector active with enable low");
    AST_BACKUP_DET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (in_backup && !detect_in_backup_instr_q) |=> !detector_active_out)
        else $error("detector active in backup without instruction");
    AST_ENTER: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (enter_ok && !cold_event) |=> backup_out && osc_stop_out)
        else $error("arm then enter did not enter backup");
    AST_NOP_ENTER: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (in_run && !arm_q && !cold_event) |=> !backup_out)
        else $error("enter without arm entered backup");
    AST_WARM: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wake_event && !cold_event) |=> ##1 powerdown_flag_out && !backup_out)
        else $error("warm return wrong");
    AST_COLD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        cold_event |=> ##1 !powerdown_flag_out)
        else $error("cold start did not clear flag");
    AST_SP: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        enter_ok |=> stack_pointer_out == `SP_INIT_VALUE)
        else $error("stack pointer not seven");
    AST_CNTR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        backup_out |-> !counter_io_pin_o_out)
        else $error("counter pin not low in backup");

    // ------------------------------------------------------------
    // assertions on detector validity
    // ------------------------------------------------------------
    // enable pin low must never let a supply drop through
    AST_PIN_LOW_NO_RESET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !detector_enable_pin_s_q |-> !drop_reset)
        else $error("drop reset with enable low");
    // pin high while running makes the detector valid
    AST_RUN_DET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (detector_enable_pin_s_q && in_run) |=> detector_active_out)
        else $error("detector idle while running");
    // latched instruction and pin high keep it valid in back-up
    AST_BACKUP_DET_ON: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (detector_enable_pin_s_q && in_backup && detect_in_backup_instr_q) |=> detector_active_out)
        else $error("detector idle in backup after instruction");
    // latch holds until a system reset
    AST_DETECT_IN_BACKUP_INSTR_HOLD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (detect_in_backup_instr_q && state_q != ST_RESET) |=> detect_in_backup_instr_q)
        else $error("detect latch lost without reset");
    // system reset cancels the latch
    AST_DETECT_IN_BACKUP_INSTR_CLEAR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (state_q == ST_RESET) |=> !detect_in_backup_instr_q)
        else $error("detect latch survived reset");

    // ------------------------------------------------------------
    // assertions on back-up entry
    // ------------------------------------------------------------
    // lone enter behaves as a no-op
    AST_NOP_STAYS_RUN: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (in_run && instr_in.enter && !arm_q && !cold_event) |=> !backup_out && !system_reset_out)
        else $error("lone enter left run");
    // any other strobe drops the arm latch
    AST_ARM_CLEAR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (in_run && !cold_event && !instr_in.arm && (instr_in.other ||
         instr_in.skip_if_powerdown || instr_in.detect_in_backup)) |=> !arm_q)
        else $error("arm kept after other instruction");
    // oscillator stops whenever back-up stands
    AST_OSC_STOP: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        backup_out |-> osc_stop_out)
        else $error("oscillator running in backup");
    // core register init strobe on entry
    AST_CORE_INIT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        enter_ok |=> core_init_out)
        else $error("core init missing on entry");
    // watchdog init strobe on entry
    AST_WD_INIT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        enter_ok |=> watchdog_init_out)
        else $error("watchdog init missing on entry");
    // watchdog enable flag back at its initial value
    AST_WEF_INIT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        enter_ok |=> watchdog_enable_flag_out)
        else $error("watchdog enable flag not initialised");
    // counter pin driven low unless counter input selected
    AST_CNTR_DRIVE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (state_d == ST_BACKUP && !cnt_input) |=> counter_io_pin_oe_out)
        else $error("counter pin not driven in backup");
    // counter input selected releases the pin
    AST_CNTR_HIZ: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (state_d == ST_BACKUP && cnt_input) |=> !counter_io_pin_oe_out)
        else $error("counter pin driven with input selected");

    // ------------------------------------------------------------
    // assertions on return and restart
    // ------------------------------------------------------------
    // without wakeup or cold source back-up stays
    AST_NO_SELF_WAKE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (in_backup && !wake_s_q && !cold_event) |=> backup_out)
        else $error("backup left without wakeup");
    // skip taken when the flag is set
    AST_SKIP_WARM: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (in_run && instr_in.skip_if_powerdown && pflag_q) |=> skip_out)
        else $error("skip missing on warm flag");
    // no skip when the flag is clear
    AST_SKIP_COLD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !pflag_q |=> !skip_out)
        else $error("skip taken on cold flag");
    // restart address is the reset vector
    AST_PC_ZERO: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        system_reset_out |-> pc_load_out == `RESET_VECTOR_ADDR)
        else $error("restart address not zero");

    // helper: length of the current system reset pulse, saturating
    logic [3:0] rst_len_q;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_len_q <= 4'h0;
        end else if (!system_reset_out) begin
            rst_len_q <= 4'h0;
        end else if (rst_len_q != 4'hf) begin
            rst_len_q <= rst_len_q + 4'h1;
        end
    end
    // every system reset pulse lasts the full count
    AST_RESET_LEN: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $fell(system_reset_out) |-> rst_len_q >= RESET_CYCLES)
        else $error("system reset pulse too short");

endmodule

// ### core/power_seq_consts.svh
// timing counts, mode encodings and reset values of the power sequencer
`ifndef POWER_SEQ_CONSTS_SVH
`define POWER_SEQ_CONSTS_SVH
`define SP_INIT_VALUE      3'h7
`define RESET_VECTOR_ADDR  14'h0000
`define PFLAG_WARM         1'b1
`define PFLAG_COLD         1'b0
`define CNTR_MODE_INPUT    2'h3
`define RESET_PULSE_CYCLES 4'h4
`define MR_RESET_VALUE     4'hf
`define WEF_RESET_VALUE    1'b1
`endif

// ### core/power_seq_pkg.sv
// types shared by the power sequencer
package power_seq_pkg;
    typedef enum logic [1:0] {
        INSTR_NONE,
        INSTR_OTHER,
        INSTR_ARM,
        INSTR_ENTER
    } instr_kind_e;

    // one-cycle instruction strobes from the cpu sequencer
    typedef struct packed {
        logic arm;
        logic enter;
        logic detect_in_backup;
        logic software_reset;
        logic skip_if_powerdown;
        logic other;
    } instr_s;

    // cold reset sources
    typedef struct packed {
        logic reset_pin;
        logic watchdog;
    } reset_src_s;
endpackage

// ### testbench/cpu_model.sv
// cpu instruction sequencer and wakeup/reset pin model
`timescale 1ns/1ps
module cpu_model (
    input  wire logic                 clk_in,
    output power_seq_pkg::instr_s     instr_out,
    output power_seq_pkg::reset_src_s reset_src_out,
    output logic                      wakeup_out
);
    // pins stay inactive until commanded
    initial begin
        instr_out = '0;
        reset_src_out = '0;
        wakeup_out = 1'b0;
    end
    // one strobe a cycle, set at the falling edge; the next call replaces it
    task automatic issue(input power_seq_pkg::instr_s s);
        @(negedge clk_in);
        instr_out = s;
    endtask
    // hold a cold source or the wakeup pin for n cycles, then release
    task automatic hold(input power_seq_pkg::reset_src_s s, input logic wk, input int n);
        @(negedge clk_in);
        reset_src_out = s;
        wakeup_out = wk;
        repeat (n) @(negedge clk_in);
        reset_src_out = '0;
        wakeup_out = 1'b0;
    endtask
endmodule

// ### testbench/test_low_voltage_reset_and_ram_retention.sv
// self-checking bench for the power sequencer
`timescale 1ns/1ps
module test_low_voltage_reset_and_ram_retention;
    localparam logic [5:0] I_ARM = 6'h20, I_ENT = 6'h10, I_DET = 6'h08;
    localparam logic [5:0] I_SWR = 6'h04, I_SKP = 6'h02, I_OTH = 6'h01, I_NONE = 6'h00;
    logic                      clk_in = 1'b0;
    logic                      arst_n_in, det_pin, supply_low, mode_hi, mode_lo, wake;
    power_seq_pkg::instr_s     instr;
    power_seq_pkg::reset_src_s rsrc;
    logic                      sys_rst, osc_stop, backup, det_act, pflag, skip;
    logic                      core_init, wd_init, watchdog_enable_flag, cnt_o, cnt_oe;
    logic [2:0]                sp;
    logic [13:0]               pc;
    logic [31:0]               r;
    logic                      rst_seen, init_seen, skip_seen, exp_bit;
    int                        errors = 0, checked = 0, cycles = 0, seed = 70;

    always #4 clk_in = ~clk_in;

    cpu_model cpu (.clk_in(clk_in), .instr_out(instr), .reset_src_out(rsrc), .wakeup_out(wake));
    power_seq #(.RESET_CYCLES(4)) dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .instr_in(instr), .reset_src_in(rsrc),
        .detector_enable_pin_in(det_pin), .supply_low_in(supply_low), .wakeup_in(wake),
        .counter_mode_bit_hi_in(mode_hi), .counter_mode_bit_lo_in(mode_lo),
        .system_reset_out(sys_rst), .osc_stop_out(osc_stop), .backup_out(backup),
        .detector_active_out(det_act), .powerdown_flag_out(pflag), .skip_out(skip),
        .core_init_out(core_init), .stack_pointer_out(sp), .watchdog_init_out(wd_init),
        .watchdog_enable_flag_out(watchdog_enable_flag), .counter_io_pin_o_out(cnt_o),
        .counter_io_pin_oe_out(cnt_oe), .pc_load_out(pc));

    // sticky records of the reset, init and skip pulses, plus the hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (sys_rst === 1'b1) rst_seen = 1'b1;
        if (core_init === 1'b1 && wd_init === 1'b1) init_seen = 1'b1;
        if (skip === 1'b1) skip_seen = 1'b1;
        if (cycles > 3000) begin
            errors++;
            end_of_test();
        end
    end

    // compare helpers and expectations
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        if (errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wait_run();
        for (int i = 0; i < 40 && sys_rst !== 1'b0; i++) @(negedge clk_in);
        chk("system_reset_out", 16'h0, {15'h0, sys_rst});
    endtask
    task automatic run_seq(input logic [5:0] a, input logic [5:0] b, input logic [5:0] c);
        cpu.issue(a);
        cpu.issue(b);
        cpu.issue(c);
        cpu.issue(I_NONE);
        repeat (3) @(negedge clk_in);
    endtask
    function automatic logic [1:0] exp_pin(input logic hi, input logic lo);
        return (hi && lo) ? 2'b00 : 2'b01;
    endfunction
    function automatic logic exp_det(input logic pin, input logic bk, input logic latch);
        return pin && (!bk || latch);
    endfunction

    // main sequence
    initial begin
        {arst_n_in, det_pin, supply_low, mode_hi, mode_lo} = '0;
        {rst_seen, init_seen, skip_seen} = '0;
        repeat (5) @(negedge clk_in);
        chk("system_reset_out", 16'h1, {15'h0, sys_rst});
        chk("stack_pointer_out", 16'h7, {13'h0, sp});
        chk("watchdog_enable_flag_out", 16'h1, {15'h0, watchdog_enable_flag});
        arst_n_in = 1'b1;
        wait_run();
        supply_low = 1'b1;
        repeat (8) @(negedge clk_in);
        chk("system_reset_out", 16'h0, {15'h0, sys_rst});
        supply_low = 1'b0;
        run_seq(I_OTH, I_OTH, I_ENT);
        chk("backup_out", 16'h0, {15'h0, backup});
        run_seq(I_ARM, I_OTH, I_ENT);
        chk("backup_out", 16'h0, {15'h0, backup});
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            {mode_hi, mode_lo} = r[1:0];
            det_pin = r[2] | (i == 3);
            repeat (6) @(negedge clk_in);
            exp_bit = exp_det(det_pin, 1'b0, 1'b0);
            chk("detector_active_out", {15'h0, exp_bit}, {15'h0, det_act});
            init_seen = 1'b0;
            run_seq(i[0] ? I_DET : I_OTH, I_ARM, I_ENT);
            chk("backup_out", 16'h1, {15'h0, backup});
            chk("osc_stop_out", 16'h1, {15'h0, osc_stop});
            chk("stack_pointer_out", 16'h7, {13'h0, sp});
            chk("init pulses", 16'h1, {15'h0, init_seen});
            chk("watchdog_enable_flag_out", 16'h1, {15'h0, watchdog_enable_flag});
            chk("counter pin", {14'h0, exp_pin(mode_hi, mode_lo)}, {14'h0, cnt_o, cnt_oe});
            exp_bit = exp_det(det_pin, 1'b1, i[0]);
            chk("detector_active_out", {15'h0, exp_bit}, {15'h0, det_act});
            cpu.hold(2'h0, 1'b1, 8);
            repeat (3) @(negedge clk_in);
            chk("backup_out", 16'h0, {15'h0, backup});
            chk("powerdown_flag_out", 16'h1, {15'h0, pflag});
            chk("pc_load_out", 16'h0, {2'h0, pc});
            skip_seen = 1'b0;
            run_seq(I_NONE, I_SKP, I_NONE);
            chk("skip_out", 16'h1, {15'h0, skip_seen});
            rst_seen = 1'b0;
            case (i)
                0: run_seq(I_NONE, I_SWR, I_NONE);
                1: cpu.hold(2'h1, 1'b0, 1);
                2: cpu.hold(2'h2, 1'b0, 6);
                default: begin
                    supply_low = 1'b1;
                    repeat (6) @(negedge clk_in);
                    supply_low = 1'b0;
                end
            endcase
            repeat (6) @(negedge clk_in);
            chk("system_reset_out seen", 16'h1, {15'h0, rst_seen});
            wait_run();
            chk("powerdown_flag_out", 16'h0, {15'h0, pflag});
            skip_seen = 1'b0;
            run_seq(I_NONE, I_SKP, I_NONE);
            chk("skip_out cold", 16'h0, {15'h0, skip_seen});
        end
        end_of_test();
    end
endmodule
